// *** design/ifeb_bank.sv ***
// Purpose: request flag and enable bank for eight primary vectors and
//	two multi-function groups
// Assumes: event pulses and service acks come from core_clk logic
// Notes: service_ack and status share one layout: bits 7..4 are the
//	flags of ctrl_b, bits 3..0 those of ctrl_c
`timescale 1ns/10ps

module ifeb_bank
	import ifeb_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [IFEB_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire ifeb_event_type events,
	input wire logic global_allow,
	input wire logic [7:0] service_ack,
	output logic [7:0] vector_req,
	output logic group0_set,
	output logic irq
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// software write replaces the byte, service clears, hardware set
	// wins over both so an event in the clearing cycle is kept
	function automatic logic [7:0] upd(input logic [7:0] cur,
		input logic we, input logic [7:0] wd, input logic [7:0] set,
		input logic [7:0] clr);
		logic [7:0] base;
		base = we ? wd : (cur & ~clr);
		return base | set;
	endfunction

	// flags of a byte masked by their own enables
	function automatic logic [3:0] armed(input logic [7:0] r);
		return r[IFEB_FLAG_LSB+:4] & r[IFEB_EN_LSB+:4];
	endfunction

	ifeb_state_type s_q, s_d;
	logic [7:0] set_b, set_c, set_ga, set_gb, clr_b, clr_c, ev_stat;
	logic grp1_raise, grp0_raise;

	// ----------------------------------------------------------------
	// set and clear terms
	// ----------------------------------------------------------------
	// a group is raised by a member event whose enable is set
	assign grp1_raise = |({events.nvdata, events.low_voltage,
		events.periodic_timer_a, events.periodic_timer_p} &
		s_q.grp_b[IFEB_EN_LSB+:4]);
	assign grp0_raise = |({events.compact_timer_a, events.compact_timer_p,
		events.standard_timer_a, events.standard_timer_p} &
		s_q.grp_a[IFEB_EN_LSB+:4]);
	// flag bits of each byte, in bit order 7..4
	assign set_b = {events.timebase1, events.timebase0,
		events.converter_done, grp1_raise, 4'h0};
	assign set_c = {events.serial_async, events.serial_module,
		events.comparator1, events.ext_pin1, 4'h0};
	assign set_ga = {events.compact_timer_a, events.compact_timer_p,
		events.standard_timer_a, events.standard_timer_p,
		4'h0};
	assign set_gb = {events.nvdata, events.low_voltage,
		events.periodic_timer_a, events.periodic_timer_p,
		4'h0};
	// servicing clears only the vector flag; group members stay set
	assign clr_b = {service_ack[7:4], 4'h0};
	assign clr_c = {service_ack[3:0], 4'h0};
	assign ev_stat = {set_b[7:4], set_c[7:4]};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic wr_b, wr_c, wr_ga, wr_gb, wr_st, wr_mk;
		wr_b = 1'b0;
		wr_c = 1'b0;
		wr_ga = 1'b0;
		wr_gb = 1'b0;
		wr_st = 1'b0;
		wr_mk = 1'b0;
		s_d = s_q;
		if (reg_wr) begin
			wr_b = (reg_addr == IFEB_OFS_CTRL_B);
			wr_c = (reg_addr == IFEB_OFS_CTRL_C);
			wr_ga = (reg_addr == IFEB_OFS_GRP_A);
			wr_gb = (reg_addr == IFEB_OFS_GRP_B);
			wr_st = (reg_addr == IFEB_OFS_STATUS);
			wr_mk = (reg_addr == IFEB_OFS_MASK);
		end
		// condition pulses set flags regardless of enable
		s_d.ctrl_b = upd(s_q.ctrl_b, wr_b, reg_wdata, set_b, clr_b);
		s_d.ctrl_c = upd(s_q.ctrl_c, wr_c, reg_wdata, set_c, clr_c);
		s_d.grp_a = upd(s_q.grp_a, wr_ga, reg_wdata, set_ga, 8'h00);
		s_d.grp_b = upd(s_q.grp_b, wr_gb, reg_wdata, set_gb, 8'h00);
		// sticky status: write one clears, a new event wins
		s_d.status = (s_q.status & ~(wr_st ? reg_wdata : 8'h00)) | ev_stat;
		if (wr_mk) begin
			s_d.mask = reg_wdata;
		end
		s_d.irq = |(s_d.status & s_d.mask);
		// a vector is requested only with enable and global allow
		s_d.vec_req = {armed(s_q.ctrl_b), armed(s_q.ctrl_c)} &
			{8{global_allow}};
		// group0 itself lives outside; hand it the raise pulse
		s_d.group0_set = grp0_raise;
		// read data stand for one cycle only, unmapped reads zero
		s_d.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				IFEB_OFS_CTRL_B: s_d.rdata = s_q.ctrl_b;
				IFEB_OFS_CTRL_C: s_d.rdata = s_q.ctrl_c;
				IFEB_OFS_GRP_A: s_d.rdata = s_q.grp_a;
				IFEB_OFS_GRP_B: s_d.rdata = s_q.grp_b;
				IFEB_OFS_STATUS: s_d.rdata = s_q.status;
				IFEB_OFS_MASK: s_d.rdata = s_q.mask;
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_q <= '{ctrl_b: IFEB_RST_BYTE, ctrl_c: IFEB_RST_BYTE,
				grp_a: IFEB_RST_BYTE, grp_b: IFEB_RST_BYTE,
				status: IFEB_RST_BYTE, mask: IFEB_RST_BYTE,
				rdata: 8'h00, vec_req: 8'h00, group0_set: 1'b0,
				irq: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign vector_req = s_q.vec_req;
	assign group0_set = s_q.group0_set;
	assign irq = s_q.irq;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	tb1_flag_set_a: assert property (
		events.timebase1 |=> s_q.ctrl_b[7])
		else $error("timebase1 event did not set its flag");
	tb0_enable_gate_a: assert property (
		s_q.ctrl_b[6] && !s_q.ctrl_b[2] |=> !vector_req[6])
		else $error("timebase0 vector without enable");
	adc_vector_a: assert property (
		s_q.ctrl_b[5] && s_q.ctrl_b[1] && global_allow |=> vector_req[5])
		else $error("converter vector missing");
	grp1_raise_a: assert property (
		events.low_voltage && s_q.grp_b[2] |=> s_q.ctrl_b[4] && s_q.grp_b[6])
		else $error("group1 not raised by enabled member");
	uart_hold_a: assert property (
		s_q.ctrl_c[7] && !reg_wr && !service_ack[3] |=> s_q.ctrl_c[7])
		else $error("async serial flag lost");
	ext1_vector_a: assert property (
		s_q.ctrl_c[4] && s_q.ctrl_c[0] && global_allow |=> vector_req[0])
		else $error("external pin1 vector missing");
	ctm_group0_a: assert property (
		events.compact_timer_a && s_q.grp_a[3] |=> group0_set)
		else $error("group0 raise pulse missing");
	stm_no_raise_a: assert property (
		events.standard_timer_a && !(|(s_q.grp_a[3:0])) && !events.compact_timer_a
		&& !events.compact_timer_p && !events.standard_timer_p |=> !group0_set)
		else $error("group0 raised with enables clear");
	global_gate_a: assert property (
		!global_allow |=> vector_req == 8'h00)
		else $error("vector requested without global allow");
	set_beats_ack_a: assert property (
		events.comparator1 && service_ack[1] |=> s_q.ctrl_c[5])
		else $error("clear won over a new comparator1 event");
	service_group_a: assert property (
		service_ack[4] && s_q.grp_b[7] && !grp1_raise && !reg_wr
		|=> !s_q.ctrl_b[4] && s_q.grp_b[7])
		else $error("service did not clear only the group flag");
	read_once_a: assert property (
		reg_rd && reg_addr == IFEB_OFS_GRP_B ##1 !reg_rd |->
		reg_rdata == $past(s_q.grp_b) ##1 reg_rdata == 8'h00)
		else $error("group_b read data wrong or held");
	irq_level_a: assert property (
		irq == |(s_q.status & s_q.mask))
		else $error("irq disagrees with status and mask");

	// per-source flag capture: each pulse must land in its own bit,
	// whatever the enable or the bus does in the same cycle
	tb0_flag_set_a: assert property (
		events.timebase0 |=> s_q.ctrl_b[6])
		else $error("timebase0 event did not set its flag");
	adc_flag_set_a: assert property (
		events.converter_done |=> s_q.ctrl_b[5])
		else $error("converter event did not set its flag");
	uart_flag_set_a: assert property (
		events.serial_async |=> s_q.ctrl_c[7])
		else $error("async serial event did not set its flag");
	usm_flag_set_a: assert property (
		events.serial_module |=> s_q.ctrl_c[6])
		else $error("serial module event did not set its flag");
	cmp1_flag_set_a: assert property (
		events.comparator1 |=> s_q.ctrl_c[5])
		else $error("comparator1 event did not set its flag");
	ext1_flag_set_a: assert property (
		events.ext_pin1 |=> s_q.ctrl_c[4])
		else $error("external pin1 event did not set its flag");
	ctma_flag_set_a: assert property (
		events.compact_timer_a |=> s_q.grp_a[7])
		else $error("compact timer A event did not set its flag");
	ctmp_flag_set_a: assert property (
		events.compact_timer_p |=> s_q.grp_a[6])
		else $error("compact timer P event did not set its flag");
	stma_flag_set_a: assert property (
		events.standard_timer_a |=> s_q.grp_a[5])
		else $error("standard timer A event did not set its flag");
	stmp_flag_set_a: assert property (
		events.standard_timer_p |=> s_q.grp_a[4])
		else $error("standard timer P event did not set its flag");
	nvd_flag_set_a: assert property (
		events.nvdata |=> s_q.grp_b[7])
		else $error("nvdata event did not set its flag");
	lvd_flag_set_a: assert property (
		events.low_voltage |=> s_q.grp_b[6])
		else $error("low voltage event did not set its flag");
	ptma_flag_set_a: assert property (
		events.periodic_timer_a |=> s_q.grp_b[5])
		else $error("periodic timer A event did not set its flag");
	ptmp_flag_set_a: assert property (
		events.periodic_timer_p |=> s_q.grp_b[4])
		else $error("periodic timer P event did not set its flag");

	// vector gating per primary source; the core only sees these
	// levels, so a wrong bit here sends it to the wrong handler
	tb1_vector_a: assert property (
		s_q.ctrl_b[7] && s_q.ctrl_b[3] && global_allow |=> vector_req[7])
		else $error("timebase1 vector missing");
	tb0_vector_a: assert property (
		s_q.ctrl_b[6] && s_q.ctrl_b[2] && global_allow |=> vector_req[6])
		else $error("timebase0 vector missing");
	grp1_vector_a: assert property (
		s_q.ctrl_b[4] && s_q.ctrl_b[0] && global_allow |=> vector_req[4])
		else $error("group1 vector missing");
	uart_vector_a: assert property (
		s_q.ctrl_c[7] && s_q.ctrl_c[3] && global_allow |=> vector_req[3])
		else $error("async serial vector missing");
	usm_vector_a: assert property (
		s_q.ctrl_c[6] && s_q.ctrl_c[2] && global_allow |=> vector_req[2])
		else $error("serial module vector missing");
	cmp1_vector_a: assert property (
		s_q.ctrl_c[5] && s_q.ctrl_c[1] && global_allow |=> vector_req[1])
		else $error("comparator1 vector missing");
	uart_gate_a: assert property (
		s_q.ctrl_c[7] && !s_q.ctrl_c[3] |=> !vector_req[3])
		else $error("async serial vector without enable");
	usm_gate_a: assert property (
		s_q.ctrl_c[6] && !s_q.ctrl_c[2] |=> !vector_req[2])
		else $error("serial module vector without enable");
	cmp1_gate_a: assert property (
		s_q.ctrl_c[5] && !s_q.ctrl_c[1] |=> !vector_req[1])
		else $error("comparator1 vector without enable");
	ext1_gate_a: assert property (
		s_q.ctrl_c[4] && !s_q.ctrl_c[0] |=> !vector_req[0])
		else $error("external pin1 vector without enable");

	// a vector with no pending flag behind it would be spurious
	tb1_idle_a: assert property (
		!s_q.ctrl_b[7] |=> !vector_req[7])
		else $error("timebase1 vector without flag");
	tb0_idle_a: assert property (
		!s_q.ctrl_b[6] |=> !vector_req[6])
		else $error("timebase0 vector without flag");
	adc_idle_a: assert property (
		!s_q.ctrl_b[5] |=> !vector_req[5])
		else $error("converter vector without flag");
	grp1_idle_a: assert property (
		!s_q.ctrl_b[4] |=> !vector_req[4])
		else $error("group1 vector without flag");
	uart_idle_a: assert property (
		!s_q.ctrl_c[7] |=> !vector_req[3])
		else $error("async serial vector without flag");
	usm_idle_a: assert property (
		!s_q.ctrl_c[6] |=> !vector_req[2])
		else $error("serial module vector without flag");
	cmp1_idle_a: assert property (
		!s_q.ctrl_c[5] |=> !vector_req[1])
		else $error("comparator1 vector without flag");
	ext1_idle_a: assert property (
		!s_q.ctrl_c[4] |=> !vector_req[0])
		else $error("external pin1 vector without flag");

	// group members raise their group only while enabled; group0
	// is a pulse because its flag is kept outside this block
	nvd_raise_a: assert property (
		events.nvdata && s_q.grp_b[3] |=> s_q.ctrl_b[4])
		else $error("nvdata did not raise group1");
	ptma_raise_a: assert property (
		events.periodic_timer_a && s_q.grp_b[1] |=> s_q.ctrl_b[4])
		else $error("periodic timer A did not raise group1");
	ptmp_raise_a: assert property (
		events.periodic_timer_p && s_q.grp_b[0] |=> s_q.ctrl_b[4])
		else $error("periodic timer P did not raise group1");
	stma_raise_a: assert property (
		events.standard_timer_a && s_q.grp_a[1] |=> group0_set)
		else $error("standard timer A did not raise group0");
	stmp_raise_a: assert property (
		events.standard_timer_p && s_q.grp_a[0] |=> group0_set)
		else $error("standard timer P did not raise group0");
	ctmp_raise_a: assert property (
		events.compact_timer_p && s_q.grp_a[2] |=> group0_set)
		else $error("compact timer P did not raise group0");
	grp0_pulse_a: assert property (
		!grp0_raise |=> !group0_set)
		else $error("group0 raise pulse without enabled member");
	grp1_quiet_a: assert property (
		!grp1_raise && !(reg_wr && reg_addr == IFEB_OFS_CTRL_B) &&
		!s_q.ctrl_b[4] |=> !s_q.ctrl_b[4])
		else $error("group1 flag rose without a cause");

	// register port: reads answer once, unmapped space is silent,
	// mask writes land, status clears by writing ones
	unmapped_rd_a: assert property (
		reg_rd && reg_addr > IFEB_OFS_MASK |=> reg_rdata == 8'h00)
		else $error("unmapped read returned data");
	idle_rdata_a: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data shown without a read");
	mask_write_a: assert property (
		reg_wr && reg_addr == IFEB_OFS_MASK |=> s_q.mask == $past(reg_wdata))
		else $error("mask write did not land");
	mask_hold_a: assert property (
		!(reg_wr && reg_addr == IFEB_OFS_MASK) |=> $stable(s_q.mask))
		else $error("mask changed without a write");
	w1c_clear_a: assert property (
		reg_wr && reg_addr == IFEB_OFS_STATUS && reg_wdata[7] &&
		!events.timebase1 |=> !s_q.status[7])
		else $error("status bit not cleared by writing one");
	status_tb1_a: assert property (
		events.timebase1 |=> s_q.status[7])
		else $error("timebase1 event missing from status");
	status_ext1_a: assert property (
		events.ext_pin1 |=> s_q.status[0])
		else $error("external pin1 event missing from status");
	irq_rise_a: assert property (
		(s_d.status & s_d.mask) != 8'h00 |=> irq)
		else $error("irq low with an unmasked status bit");

	vec_cover_c: cover property (global_allow && vector_req[7]);
	group_cover_c: cover property (events.nvdata && s_q.grp_b[3]
		##1 s_q.ctrl_b[4] ##[1:4] service_ack[4]);
	w1c_cover_c: cover property (irq ##1 reg_wr &&
		reg_addr == IFEB_OFS_STATUS ##1 !irq);
	race_cover_c: cover property (events.timebase1 && service_ack[7]);

endmodule

// *** design/ifeb_pkg.sv ***
// Purpose: shared constants and types of the interrupt flag/enable bank
// Assumes: byte-wide registers on a plain strobe port, one clock domain
// Notes: flags sit in the high nibble, enables in the low nibble
package ifeb_pkg;

	// ----------------------------------------------------------------
	// register offsets on the strobe port
	// ----------------------------------------------------------------
	localparam int IFEB_ADDR_W = 3;
	localparam logic [2:0] IFEB_OFS_CTRL_B = 3'h0; // interrupt_ctrl_b
	localparam logic [2:0] IFEB_OFS_CTRL_C = 3'h1; // interrupt_ctrl_c
	localparam logic [2:0] IFEB_OFS_GRP_A = 3'h2; // multifunction_group_a
	localparam logic [2:0] IFEB_OFS_GRP_B = 3'h3; // multifunction_group_b
	localparam logic [2:0] IFEB_OFS_STATUS = 3'h4; // sticky events, w1c
	localparam logic [2:0] IFEB_OFS_MASK = 3'h5; // interrupt mask

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int IFEB_FLAG_LSB = 4; // flags in bits 7..4
	localparam int IFEB_EN_LSB = 0; // enables in bits 3..0
	localparam logic [7:0] IFEB_RST_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	// one-cycle condition pulses from the peripherals
	typedef struct packed {
		logic timebase1;
		logic timebase0;
		logic converter_done;
		logic serial_async;
		logic serial_module;
		logic comparator1;
		logic ext_pin1;
		logic compact_timer_a;
		logic compact_timer_p;
		logic standard_timer_a;
		logic standard_timer_p;
		logic nvdata;
		logic low_voltage;
		logic periodic_timer_a;
		logic periodic_timer_p;
	} ifeb_event_type;

	// whole state of the bank
	typedef struct packed {
		logic [7:0] ctrl_b;
		logic [7:0] ctrl_c;
		logic [7:0] grp_a;
		logic [7:0] grp_b;
		logic [7:0] status;
		logic [7:0] mask;
		logic [7:0] rdata;
		logic [7:0] vec_req;
		logic group0_set;
		logic irq;
	} ifeb_state_type;

endpackage

// *** tb/ifeb_bank_test.sv ***
// Purpose: self-checking bench of the flag and enable bank
// Assumes: bank serviced by the core model
// Notes: rows hold {event, address, flag byte, status byte}
`timescale 1ns/10ps
module ifeb_bank_test;
	import ifeb_pkg::*;
	logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic gie = 1'b0, global_allow, group0_set, irq;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, service_ack, vector_req;
	logic [3:0] ack_delay = 4'h2;
	ifeb_event_type ev = '0;
	int failures = 0, check_count = 0;
	logic [23:0] rows [15] = '{24'he08080, 24'hd04040, 24'hc02020,
		24'hb18008, 24'ha14004, 24'h912002, 24'h811001, 24'h728000,
		24'h624000, 24'h522000, 24'h421000, 24'h338000, 24'h234000,
		24'h132000, 24'h031000};
	always #4 core_clk = ~core_clk;
	ifeb_bank u_ifeb_bank (.core_clk(core_clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .events(ev),
		.global_allow(global_allow), .service_ack(service_ack),
		.vector_req(vector_req), .group0_set(group0_set), .irq(irq));
	ifeb_core_model u_ifeb_core_model (.core_clk(core_clk), .rstn(rstn),
		.vector_req(vector_req), .ack_delay(ack_delay), .gie(gie),
		.service_ack(service_ack), .global_allow(global_allow));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(logic [2:0] a, logic [7:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// one-cycle pulse; returns just after the edge that registers it
	task automatic fire(int i);
		@(posedge core_clk);
		ev <= ifeb_event_type'(15'h1 << i);
		@(posedge core_clk);
		ev <= '0;
		#1;
	endtask
	// bounded wait for masked vector_req to reach a level
	task automatic wait_vec(logic [7:0] m, logic v);
		int n;
		for (n = 0; n < 40 && ((vector_req & m) != 8'h00) !== v; n++) begin
			@(posedge core_clk);
			#1;
		end
		if (n == 40) begin
			failures++;
			$display("Error at %0t: got %h exp %h", $time, vector_req, m);
			finish_test();
		end
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		for (int a = 0; a < 8; a++) rd(3'(a), IFEB_RST_BYTE); // all clear
		for (int a = 0; a < 6; a++) begin
			if (a != 4) begin
				wr(3'(a), 8'h0f);
				rd(3'(a), 8'h0f);
				wr(3'(a), 8'h00);
			end
		end
		$display("test reset done");
		foreach (rows[k]) begin
			fire(int'(rows[k][23:20]));
			rd(rows[k][18:16], rows[k][15:8]);
			rd(IFEB_OFS_STATUS, rows[k][7:0]);
			wr(rows[k][18:16], 8'h00);
			wr(IFEB_OFS_STATUS, 8'hff);
		end
		$display("test rows done");
		// prompt and slow service; flag cleared by the ack
		for (int d = 0; d < 2; d++) begin
			ack_delay <= d ? 4'h2 : 4'h7;
			gie <= 1'b1;
			wr(IFEB_OFS_CTRL_B, 8'h02);
			fire(12);
			wait_vec(8'h20, 1'b1);
			wait_vec(8'h20, 1'b0);
			rd(IFEB_OFS_CTRL_B, 8'h02);
		end
		gie <= 1'b0;
		fire(12);
		repeat (4) @(posedge core_clk);
		chk(vector_req, 8'h00);
		rd(IFEB_OFS_CTRL_B, 8'h22);
		$display("test vector done");
		// group ack clears only the group flag
		wr(IFEB_OFS_CTRL_B, 8'h01);
		wr(IFEB_OFS_GRP_B, 8'h08);
		gie <= 1'b1;
		fire(3);
		wait_vec(8'h10, 1'b1);
		wait_vec(8'h10, 1'b0);
		rd(IFEB_OFS_CTRL_B, 8'h01);
		rd(IFEB_OFS_GRP_B, 8'h88);
		gie <= 1'b0;
		fire(2);
		rd(IFEB_OFS_CTRL_B, 8'h01);
		wr(IFEB_OFS_GRP_A, 8'h08);
		fire(7);
		chk({7'h00, group0_set}, 8'h01);
		fire(6);
		chk({7'h00, group0_set}, 8'h00);
		$display("test group done");
		wr(IFEB_OFS_STATUS, 8'hff);
		wr(IFEB_OFS_MASK, 8'h80);
		fire(13);
		chk({7'h00, irq}, 8'h00);
		fire(14);
		chk({7'h00, irq}, 8'h01);
		wr(IFEB_OFS_STATUS, 8'h80);
		#1 chk({7'h00, irq}, 8'h00);
		$display("test irq done");
		finish_test();
	end
endmodule

// *** tb/ifeb_core_model.sv ***
// Purpose: core-side model that services vector requests
// Assumes: one clock, vector requests are levels from the bank
// Notes: ack comes ack_delay cycles after a request is seen
`timescale 1ns/10ps
module ifeb_core_model
	import ifeb_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] vector_req,
	input wire logic [3:0] ack_delay,
	input wire logic gie,
	output logic [7:0] service_ack,
	output logic global_allow
);
	logic [3:0] wait_q;
	// ----------------------------------------------------------------
	// service loop
	// ----------------------------------------------------------------
	// one ack at a time, lowest bit first; keep delay above 0 or a
	// request still showing after an ack would be served twice
	always_ff @(posedge core_clk) begin
		service_ack <= 8'h00;
		global_allow <= gie;
		if (!rstn || vector_req == 8'h00 || service_ack != 8'h00) begin
			wait_q <= 4'h0;
		end else if (wait_q >= ack_delay) begin
			service_ack <= vector_req & (~vector_req + 8'h01);
			wait_q <= 4'h0;
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule
